// ===== pmic_regs_pkg.sv
// Register map, field positions and reset values of the supply control bank
package pmic_regs_pkg;
   localparam int DATA_W = 8;
   localparam logic [7:0] ADDR_ID = 8'h00;
   localparam logic [7:0] ADDR_FAULT = 8'h01;
   localparam logic [7:0] ADDR_MASK = 8'h02;
   localparam logic [7:0] ADDR_SUPPLY = 8'h03;
   localparam logic [7:0] ADDR_CONV = 8'h04;
   localparam logic [7:0] UNMAPPED_READ = 8'hff;
   localparam logic [7:0] MASK_RESET = 8'hc0;
   localparam logic [7:0] SUPPLY_RESET = 8'hff;
   localparam logic [7:0] CONV_RESET = 8'hb1;
   localparam logic [7:0] FAULT_RESET = 8'h00;
   // Bit positions shared by fault and mask registers; supply enable uses bits 5:1 only
   localparam int BIT_POWER_FAIL = 7;
   localparam int BIT_LOW_BATT = 6;
   localparam int BIT_BUCK1 = 5;
   localparam int BIT_BUCK2 = 4;
   localparam int BIT_BUCK3 = 3;
   localparam int BIT_LINEAR2 = 2;
   localparam int BIT_LINEAR1 = 1;
   // Converter control fields
   localparam int PHASE_BUCK2_HI = 7;
   localparam int PHASE_BUCK2_LO = 6;
   localparam int PHASE_BUCK3_HI = 5;
   localparam int PHASE_BUCK3_LO = 4;
   localparam int BIT_LOW_RIPPLE = 3;
   localparam int BIT_FIXED_BUCK2 = 2;
   localparam int BIT_FIXED_BUCK1 = 1;
   localparam int BIT_FIXED_BUCK3 = 0;
   // Supplies that have a fault comparator and an enable bit
   localparam logic [7:0] SUPPLY_BITS = 8'h3e;
endpackage

// ===== fault_if.sv
// Fault flag, mask and interrupt request carrier between register bank and gate
`timescale 1ns/100ps
`default_nettype none
interface fault_if;
   logic [7:0] flags;
   logic [7:0] mask;
   logic rd_flags;
   logic [7:0] blocked;
   logic int_req;
   modport bank (output flags, output mask, output rd_flags, input blocked, input int_req);
   modport gate (input flags, input mask, input rd_flags, output blocked, output int_req);
endinterface
`default_nettype wire

// ===== fault_int_gate.sv
// Read blocking and masking of fault flags onto the interrupt request
`timescale 1ns/100ps
`default_nettype none
module fault_int_gate (
   input wire logic ref_clk_i,
   input wire logic sys_rst_i,
   input wire logic undervoltage_lockout_i,
   fault_if.gate fif
);
   logic [7:0] blocked_q;

   // Flags active at a read stop driving the interrupt; a bit unblocks once
   // its flag drops, so a later fault is reported again.
   always_ff @(posedge ref_clk_i) begin
      if (sys_rst_i || undervoltage_lockout_i) begin
         blocked_q <= pmic_regs_pkg::FAULT_RESET;
      end else if (fif.rd_flags) begin
         blocked_q <= (blocked_q & fif.flags) | fif.flags;
      end else begin
         blocked_q <= blocked_q & fif.flags;
      end
   end

   assign fif.blocked = blocked_q;
   assign fif.int_req = |(fif.flags & ~fif.mask & ~blocked_q);

   property p_read_blocks;
      @(posedge ref_clk_i) disable iff (sys_rst_i || undervoltage_lockout_i)
         fif.rd_flags |=> ((~blocked_q & $past(fif.flags) & fif.flags) == 8'h00);
   endproperty
   a_read_blocks: assert property (p_read_blocks) else $error("read did not block flags");
endmodule
`default_nettype wire

// ===== pmic_supply_control_regs.sv
// Fault, mask, supply enable and converter control registers of the supply device
// How it works
// - Linear regulator 2 fault reads 1 when below target, 0 when in range or off.
// - Linear regulator 1 fault reads 1 when below target, 0 when in range or off.
// - Fault mask at 02h loads C0h on undervoltage lockout.
// - A mask bit of 1 keeps the same-position fault off the interrupt.
// - A supply runs only when its enable bit and enable pin are both high.
// - Undervoltage lockout sets all supply-enable bits, so pins alone decide.
// - A low enable pin forces its supply-enable bit back to 1.
// - Enable bits: buck1 bit 5, buck2 4, buck3 3, linear2 2, linear1 1.
// - Host may write 0 or 1 to each enable bit; it holds until reset or until its enable pin goes low.
// - The one shared linear-regulator pin restores both linear enable bits.
// - Supply-enable register at 03h resets to FFh, unused bits included.
// - Converter control at 04h is read/write and loads B1h on lockout.
// - Bits 7:6 delay buck2 against buck1 in quarter cycles; buck1 has zero phase.
// - Bits 5:4 delay buck3 against buck1 with the same quarter-step code.
// - Bit 3 picks light-load behaviour: 0 efficiency, 1 low ripple.
// - Bit 2 forces buck2 to fixed frequency; 0 allows automatic mode change.
// - Bit 1 forces buck1 to fixed frequency; 0 allows automatic mode change.
// - Bit 0 forces buck3 to fixed frequency; 0 allows automatic mode change.
// - Reading the fault register blocks the flags then active from the interrupt.
`timescale 1ns/100ps
`default_nettype none
module pmic_supply_control_regs #(
   // Arbitrary identification value
   parameter logic [7:0] ID_VALUE = 8'h5a
) (
   input wire logic ref_clk_i,
   input wire logic sys_rst_i,
   input wire logic undervoltage_lockout_i,
   input wire logic [7:0] reg_addr_i,
   input wire logic [7:0] reg_wdata_i,
   input wire logic reg_wr_i,
   input wire logic reg_rd_i,
   output logic [7:0] reg_rdata_o,
   input wire logic power_fail_i,
   input wire logic low_battery_i,
   input wire logic buck1_below_i,
   input wire logic buck2_below_i,
   input wire logic buck3_below_i,
   input wire logic linear2_below_i,
   input wire logic linear1_below_i,
   input wire logic buck1_enable_pin_i,
   input wire logic buck2_enable_pin_i,
   input wire logic buck3_enable_pin_i,
   input wire logic linear_reg_enable_pin_i,
   output logic buck1_on_o,
   output logic buck2_on_o,
   output logic buck3_on_o,
   output logic linear2_on_o,
   output logic linear1_on_o,
   output logic [1:0] phase_delay_buck2_o,
   output logic [1:0] phase_delay_buck3_o,
   output logic low_ripple_o,
   output logic forced_fixed_freq_buck1_o,
   output logic forced_fixed_freq_buck2_o,
   output logic forced_fixed_freq_buck3_o,
   input wire logic int_pin_i,
   output logic int_pin_o,
   output logic int_pin_oe_n_o
);
   logic load_defaults;
   logic [7:0] pins;
   logic [7:0] below;
   logic [7:0] enabled_now;
   logic [7:0] fault_d;
   logic [7:0] power_fault_flags_q;
   logic [7:0] fault_mask_q;
   logic [7:0] supply_enable_ctrl_q;
   logic [7:0] converter_mode_ctrl_q;
   logic [7:0] rdata_d;
   logic wr_mask;
   logic wr_supply;
   logic wr_conv;
   logic int_line_seen;

   fault_if fif ();

   fault_int_gate i_fault_int_gate (
      .ref_clk_i(ref_clk_i),
      .sys_rst_i(sys_rst_i),
      .undervoltage_lockout_i(undervoltage_lockout_i),
      .fif(fif.gate)
   );

   assign load_defaults = sys_rst_i || undervoltage_lockout_i;
   assign wr_mask = reg_wr_i && (reg_addr_i == pmic_regs_pkg::ADDR_MASK);
   assign wr_supply = reg_wr_i && (reg_addr_i == pmic_regs_pkg::ADDR_SUPPLY);
   assign wr_conv = reg_wr_i && (reg_addr_i == pmic_regs_pkg::ADDR_CONV);

   // Pins laid out on enable-register positions; bits without a pin read high
   always_comb begin
      pins = 8'hff;
      pins[pmic_regs_pkg::BIT_BUCK1] = buck1_enable_pin_i;
      pins[pmic_regs_pkg::BIT_BUCK2] = buck2_enable_pin_i;
      pins[pmic_regs_pkg::BIT_BUCK3] = buck3_enable_pin_i;
      pins[pmic_regs_pkg::BIT_LINEAR2] = linear_reg_enable_pin_i;
      pins[pmic_regs_pkg::BIT_LINEAR1] = linear_reg_enable_pin_i;
   end

   always_comb begin
      below = 8'h00;
      below[pmic_regs_pkg::BIT_BUCK1] = buck1_below_i;
      below[pmic_regs_pkg::BIT_BUCK2] = buck2_below_i;
      below[pmic_regs_pkg::BIT_BUCK3] = buck3_below_i;
      below[pmic_regs_pkg::BIT_LINEAR2] = linear2_below_i;
      below[pmic_regs_pkg::BIT_LINEAR1] = linear1_below_i;
   end

   assign enabled_now = supply_enable_ctrl_q & pins;

   // Supply flags read 1 only while enabled and below target
   always_comb begin
      fault_d = below & enabled_now & pmic_regs_pkg::SUPPLY_BITS;
      fault_d[pmic_regs_pkg::BIT_POWER_FAIL] = power_fail_i;
      fault_d[pmic_regs_pkg::BIT_LOW_BATT] = low_battery_i;
   end

   always_ff @(posedge ref_clk_i) begin
      if (load_defaults) begin
         power_fault_flags_q <= pmic_regs_pkg::FAULT_RESET;
      end else begin
         power_fault_flags_q <= fault_d;
      end
   end

   always_ff @(posedge ref_clk_i) begin
      if (load_defaults) begin
         fault_mask_q <= pmic_regs_pkg::MASK_RESET;
      end else if (wr_mask) begin
         fault_mask_q <= reg_wdata_i;
      end
   end

   // A low pin wins over a host write in the same cycle
   always_ff @(posedge ref_clk_i) begin
      if (load_defaults) begin
         supply_enable_ctrl_q <= pmic_regs_pkg::SUPPLY_RESET;
      end else if (wr_supply) begin
         supply_enable_ctrl_q <= reg_wdata_i | ~pins;
      end else begin
         supply_enable_ctrl_q <= supply_enable_ctrl_q | ~pins;
      end
   end

   always_ff @(posedge ref_clk_i) begin
      if (load_defaults) begin
         converter_mode_ctrl_q <= pmic_regs_pkg::CONV_RESET;
      end else if (wr_conv) begin
         converter_mode_ctrl_q <= reg_wdata_i;
      end
   end

   assign fif.flags = power_fault_flags_q;
   assign fif.mask = fault_mask_q;
   assign fif.rd_flags = reg_rd_i && (reg_addr_i == pmic_regs_pkg::ADDR_FAULT);

   always_comb begin
      unique case (reg_addr_i)
         pmic_regs_pkg::ADDR_ID: rdata_d = ID_VALUE;
         pmic_regs_pkg::ADDR_FAULT: rdata_d = power_fault_flags_q;
         pmic_regs_pkg::ADDR_MASK: rdata_d = fault_mask_q;
         pmic_regs_pkg::ADDR_SUPPLY: rdata_d = supply_enable_ctrl_q;
         pmic_regs_pkg::ADDR_CONV: rdata_d = converter_mode_ctrl_q;
         default: rdata_d = pmic_regs_pkg::UNMAPPED_READ;
      endcase
   end

   always_ff @(posedge ref_clk_i) begin
      if (sys_rst_i) begin
         reg_rdata_o <= pmic_regs_pkg::UNMAPPED_READ;
      end else if (reg_rd_i) begin
         reg_rdata_o <= rdata_d;
      end
   end

   always_ff @(posedge ref_clk_i) begin
      if (sys_rst_i) begin
         buck1_on_o <= 1'b0;
         buck2_on_o <= 1'b0;
         buck3_on_o <= 1'b0;
         linear2_on_o <= 1'b0;
         linear1_on_o <= 1'b0;
      end else begin
         buck1_on_o <= enabled_now[pmic_regs_pkg::BIT_BUCK1];
         buck2_on_o <= enabled_now[pmic_regs_pkg::BIT_BUCK2];
         buck3_on_o <= enabled_now[pmic_regs_pkg::BIT_BUCK3];
         linear2_on_o <= enabled_now[pmic_regs_pkg::BIT_LINEAR2];
         linear1_on_o <= enabled_now[pmic_regs_pkg::BIT_LINEAR1];
      end
   end

   // Buck1 is the phase reference, so it has no delay field
   always_ff @(posedge ref_clk_i) begin
      if (sys_rst_i) begin
         phase_delay_buck2_o <= 2'h0;
         phase_delay_buck3_o <= 2'h0;
         low_ripple_o <= 1'b0;
         forced_fixed_freq_buck1_o <= 1'b0;
         forced_fixed_freq_buck2_o <= 1'b0;
         forced_fixed_freq_buck3_o <= 1'b0;
      end else begin
         phase_delay_buck2_o <= converter_mode_ctrl_q[pmic_regs_pkg::PHASE_BUCK2_HI:
            pmic_regs_pkg::PHASE_BUCK2_LO];
         phase_delay_buck3_o <= converter_mode_ctrl_q[pmic_regs_pkg::PHASE_BUCK3_HI:
            pmic_regs_pkg::PHASE_BUCK3_LO];
         low_ripple_o <= converter_mode_ctrl_q[pmic_regs_pkg::BIT_LOW_RIPPLE];
         forced_fixed_freq_buck2_o <= converter_mode_ctrl_q[pmic_regs_pkg::BIT_FIXED_BUCK2];
         forced_fixed_freq_buck1_o <= converter_mode_ctrl_q[pmic_regs_pkg::BIT_FIXED_BUCK1];
         forced_fixed_freq_buck3_o <= converter_mode_ctrl_q[pmic_regs_pkg::BIT_FIXED_BUCK3];
      end
   end

   // Open drain: level held at 0, enable low pulls the line
   always_ff @(posedge ref_clk_i) begin
      if (sys_rst_i) begin
         int_pin_o <= 1'b0;
         int_pin_oe_n_o <= 1'b1;
      end else begin
         int_pin_o <= 1'b0;
         int_pin_oe_n_o <= ~fif.int_req;
      end
   end

   // Line level as seen on the wire, kept for observation only
   always_ff @(posedge ref_clk_i) begin
      if (sys_rst_i) begin
         int_line_seen <= 1'b1;
      end else begin
         int_line_seen <= int_pin_i;
      end
   end

   default clocking cb @(posedge ref_clk_i);
   endclocking
   default disable iff (sys_rst_i);

   property p_linear2_off_flag;
      !undervoltage_lockout_i && !enabled_now[pmic_regs_pkg::BIT_LINEAR2]
         |=> !power_fault_flags_q[pmic_regs_pkg::BIT_LINEAR2];
   endproperty
   a_linear2_off_flag: assert property (p_linear2_off_flag) else $error("ldo2 flag set while off");

   property p_linear1_low_flag;
      !undervoltage_lockout_i && linear1_below_i && enabled_now[pmic_regs_pkg::BIT_LINEAR1]
         |=> power_fault_flags_q[pmic_regs_pkg::BIT_LINEAR1];
   endproperty
   a_linear1_low_flag: assert property (p_linear1_low_flag) else $error("ldo1 flag missing");

   property p_mask_default;
      undervoltage_lockout_i |=> fault_mask_q == pmic_regs_pkg::MASK_RESET;
   endproperty
   a_mask_default: assert property (p_mask_default) else $error("mask not C0h after lockout");

   property p_masked_quiet;
      (fif.int_req == 1'b0) |=> int_pin_oe_n_o;
   endproperty
   a_masked_quiet: assert property (p_masked_quiet) else $error("interrupt driven with no cause");

   property p_int_drive;
      |(power_fault_flags_q & ~fault_mask_q & ~fif.blocked) |=> !int_pin_oe_n_o;
   endproperty
   a_int_drive: assert property (p_int_drive) else $error("interrupt not driven");

   property p_supply_and;
      !sys_rst_i |=> buck1_on_o == $past(supply_enable_ctrl_q[5] && buck1_enable_pin_i);
   endproperty
   a_supply_and: assert property (p_supply_and) else $error("buck1 state not AND of bit and pin");

   property p_enable_default;
      undervoltage_lockout_i |=> supply_enable_ctrl_q == pmic_regs_pkg::SUPPLY_RESET;
   endproperty
   a_enable_default: assert property (p_enable_default) else $error("enable reg not FFh");

   property p_pin_restore;
      !linear_reg_enable_pin_i |=> supply_enable_ctrl_q[2] && supply_enable_ctrl_q[1];
   endproperty
   a_pin_restore: assert property (p_pin_restore) else $error("linear enables not restored");

   sequence s_enable_write;
      wr_supply && !undervoltage_lockout_i && (pins == 8'hff);
   endsequence
   sequence s_quiet_hold;
      !reg_wr_i && !undervoltage_lockout_i && (pins == 8'hff);
   endsequence
   property p_write_holds;
      s_enable_write ##1 s_quiet_hold |=> supply_enable_ctrl_q == $past(reg_wdata_i, 2);
   endproperty
   a_write_holds: assert property (p_write_holds) else $error("enable write not held");

   property p_conv_default;
      undervoltage_lockout_i |=> converter_mode_ctrl_q == pmic_regs_pkg::CONV_RESET;
   endproperty
   a_conv_default: assert property (p_conv_default) else $error("converter ctrl not B1h");

   property p_phase_out;
      wr_conv && !undervoltage_lockout_i |=> ##1 phase_delay_buck2_o == $past(reg_wdata_i[7:6], 2);
   endproperty
   a_phase_out: assert property (p_phase_out) else $error("buck2 phase not applied");

   property p_fixed_out;
      !sys_rst_i |=> forced_fixed_freq_buck3_o == $past(converter_mode_ctrl_q[0]);
   endproperty
   a_fixed_out: assert property (p_fixed_out) else $error("buck3 fixed mode wrong");

   property p_fixed2_out;
      !sys_rst_i |=> forced_fixed_freq_buck2_o == $past(converter_mode_ctrl_q[2]);
   endproperty
   a_fixed2_out: assert property (p_fixed2_out) else $error("buck2 fixed mode wrong");

   property p_fixed1_out;
      !sys_rst_i |=> forced_fixed_freq_buck1_o == $past(converter_mode_ctrl_q[1]);
   endproperty
   a_fixed1_out: assert property (p_fixed1_out) else $error("buck1 fixed mode wrong");

   property p_ripple_out;
      !sys_rst_i |=> low_ripple_o == $past(converter_mode_ctrl_q[3]);
   endproperty
   a_ripple_out: assert property (p_ripple_out) else $error("low ripple output wrong");

   property p_buck3_phase;
      wr_conv && !undervoltage_lockout_i |=> ##1 phase_delay_buck3_o == $past(reg_wdata_i[5:4], 2);
   endproperty
   a_buck3_phase: assert property (p_buck3_phase) else $error("buck3 phase not applied");

   property p_buck2_and;
      !sys_rst_i |=> buck2_on_o == $past(supply_enable_ctrl_q[4] && buck2_enable_pin_i);
   endproperty
   a_buck2_and: assert property (p_buck2_and) else $error("buck2 state wrong");

   property p_linear1_and;
      !sys_rst_i |=> linear1_on_o == $past(supply_enable_ctrl_q[1] && linear_reg_enable_pin_i);
   endproperty
   a_linear1_and: assert property (p_linear1_and) else $error("ldo1 state wrong");

   property p_buck1_restore;
      !buck1_enable_pin_i |=> supply_enable_ctrl_q[5];
   endproperty
   a_buck1_restore: assert property (p_buck1_restore) else $error("buck1 enable not restored");

   property p_linear2_low_flag;
      !undervoltage_lockout_i && linear2_below_i && enabled_now[pmic_regs_pkg::BIT_LINEAR2]
         |=> power_fault_flags_q[pmic_regs_pkg::BIT_LINEAR2];
   endproperty
   a_linear2_low_flag: assert property (p_linear2_low_flag) else $error("ldo2 flag missing");

   property p_line_seen;
      !int_pin_oe_n_o |=> !int_line_seen;
   endproperty
   a_line_seen: assert property (p_line_seen) else $error("interrupt line not low");
endmodule
`default_nettype wire

// ===== host_model.sv
// Host side model driving the parallel register port and the interrupt line
`timescale 1ns/100ps
`default_nettype none
module host_model (
   input wire logic ref_clk_i,
   input wire logic [7:0] reg_rdata_i,
   input wire logic int_pin_oe_n_i,
   input wire logic int_pin_drv_i,
   output logic [7:0] reg_addr_o,
   output logic [7:0] reg_wdata_o,
   output logic reg_wr_o,
   output logic reg_rd_o,
   output logic int_line_o
);
   // Pull-up holds the released interrupt line high
   assign int_line_o = int_pin_oe_n_i ? 1'b1 : int_pin_drv_i;
   initial begin
      reg_addr_o = 8'h00;
      reg_wdata_o = 8'h00;
      reg_wr_o = 1'b0;
      reg_rd_o = 1'b0;
   end
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge ref_clk_i);
      reg_addr_o <= a;
      reg_wdata_o <= d;
      reg_wr_o <= 1'b1;
      @(posedge ref_clk_i);
      reg_wr_o <= 1'b0;
      reg_wdata_o <= ~d;
   endtask
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(posedge ref_clk_i);
      reg_addr_o <= a;
      reg_rd_o <= 1'b1;
      @(posedge ref_clk_i);
      reg_rd_o <= 1'b0;
      reg_addr_o <= ~a;
      #1;
      d = reg_rdata_i;
   endtask
endmodule
`default_nettype wire

// ===== pmic_supply_control_regs_bench.sv
// Self-checking bench for the supply control register bank
`timescale 1ns/100ps
`default_nettype none
module pmic_supply_control_regs_bench;
   logic ref_clk_i, sys_rst_i, undervoltage_lockout_i, reg_wr_i, reg_rd_i;
   logic [7:0] reg_addr_i, reg_wdata_i, reg_rdata_o, v, d;
   logic power_fail_i, low_battery_i, int_pin_i, int_pin_o, int_pin_oe_n_o;
   logic [4:0] below;
   logic [3:0] pins;
   logic buck1_on_o, buck2_on_o, buck3_on_o, linear2_on_o, linear1_on_o;
   logic [1:0] phase_delay_buck2_o, phase_delay_buck3_o;
   logic low_ripple_o, forced_fixed_freq_buck1_o;
   logic forced_fixed_freq_buck2_o, forced_fixed_freq_buck3_o;
   int n_fail = 0;
   int cmp_count = 0;
   pmic_supply_control_regs #(.ID_VALUE(8'ha7)) i_pmic_supply_control_regs (
      .ref_clk_i, .sys_rst_i, .undervoltage_lockout_i, .reg_addr_i, .reg_wdata_i,
      .reg_wr_i, .reg_rd_i, .reg_rdata_o, .power_fail_i, .low_battery_i,
      .buck1_below_i(below[4]), .buck2_below_i(below[3]), .buck3_below_i(below[2]),
      .linear2_below_i(below[1]), .linear1_below_i(below[0]),
      .buck1_enable_pin_i(pins[3]), .buck2_enable_pin_i(pins[2]),
      .buck3_enable_pin_i(pins[1]), .linear_reg_enable_pin_i(pins[0]),
      .buck1_on_o, .buck2_on_o, .buck3_on_o, .linear2_on_o, .linear1_on_o,
      .phase_delay_buck2_o, .phase_delay_buck3_o, .low_ripple_o,
      .forced_fixed_freq_buck1_o, .forced_fixed_freq_buck2_o,
      .forced_fixed_freq_buck3_o, .int_pin_i, .int_pin_o, .int_pin_oe_n_o
   );
   host_model i_host_model (
      .ref_clk_i, .reg_rdata_i(reg_rdata_o), .int_pin_oe_n_i(int_pin_oe_n_o),
      .int_pin_drv_i(int_pin_o), .reg_addr_o(reg_addr_i), .reg_wdata_o(reg_wdata_i),
      .reg_wr_o(reg_wr_i), .reg_rd_o(reg_rd_i), .int_line_o(int_pin_i)
   );
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         n_fail++;
         $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic close_out();
      $display("Comparisons %0d, mismatches %0d", cmp_count, n_fail);
      if (n_fail == 0 && cmp_count > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask
   // Enable bits forced high by low pins
   function automatic logic [7:0] forced(input logic [3:0] p);
      return {2'b00, ~p[3:1], {2{~p[0]}}, 1'b0};
   endfunction
   function automatic logic [7:0] exp_on(input logic [7:0] en, input logic [3:0] p);
      return {3'b000, en[5:1] & {p[3:1], p[0], p[0]}};
   endfunction
   function automatic logic [7:0] on_now();
      return {3'b000, buck1_on_o, buck2_on_o, buck3_on_o, linear2_on_o, linear1_on_o};
   endfunction
   function automatic logic [7:0] conv_now();
      return {phase_delay_buck2_o, phase_delay_buck3_o, low_ripple_o,
         forced_fixed_freq_buck2_o, forced_fixed_freq_buck1_o, forced_fixed_freq_buck3_o};
   endfunction
   task automatic int_after(input int n, input logic exp);
      repeat (n) @(posedge ref_clk_i);
      #1;
      check({7'h00, int_pin_i}, {7'h00, exp});
   endtask
   initial begin
      ref_clk_i = 1'b0;
      forever #4 ref_clk_i = ~ref_clk_i;
   end
   initial begin
      repeat (20000) @(posedge ref_clk_i);
      n_fail++;
      close_out();
   end
   initial begin
      void'($urandom(6654));
      sys_rst_i = 1'b1;
      undervoltage_lockout_i = 1'b0;
      power_fail_i = 1'b0;
      low_battery_i = 1'b0;
      below = 5'h00;
      pins = 4'hf;
      repeat (20) @(posedge ref_clk_i);
      sys_rst_i <= 1'b0;
      i_host_model.rd(pmic_regs_pkg::ADDR_MASK, d);
      check(d, 8'hc0);
      i_host_model.rd(pmic_regs_pkg::ADDR_SUPPLY, d);
      check(d, 8'hff);
      i_host_model.rd(pmic_regs_pkg::ADDR_CONV, d);
      check(d, 8'hb1);
      check(conv_now(), 8'hb1);
      check(on_now(), 8'h1f);
      i_host_model.rd(8'h09, d);
      check(d, 8'hff);
      // Read-only registers ignore writes
      i_host_model.wr(pmic_regs_pkg::ADDR_ID, 8'h00);
      i_host_model.wr(pmic_regs_pkg::ADDR_FAULT, 8'hff);
      i_host_model.rd(pmic_regs_pkg::ADDR_ID, d);
      check(d, 8'ha7);
      i_host_model.rd(pmic_regs_pkg::ADDR_FAULT, d);
      check(d, 8'h00);
      // Phase codes and mode bits, corners then random
      for (int i = 0; i < 8; i++) begin
         v = (i < 4) ? 8'(i * 8'h55) : 8'($urandom);
         i_host_model.wr(pmic_regs_pkg::ADDR_CONV, v);
         i_host_model.rd(pmic_regs_pkg::ADDR_CONV, d);
         check(d, v);
         check(conv_now(), v);
      end
      // Enable writes against pins, some pins held low
      for (int i = 0; i < 8; i++) begin
         v = (i == 0) ? 8'hc1 : (8'($urandom) | 8'hc1);
         @(posedge ref_clk_i);
         pins <= (i < 2) ? 4'hf : 4'($urandom);
         i_host_model.wr(pmic_regs_pkg::ADDR_SUPPLY, v);
         i_host_model.rd(pmic_regs_pkg::ADDR_SUPPLY, d);
         check(d, v | forced(pins));
         check(on_now(), exp_on(v | forced(pins), pins));
      end
      @(posedge ref_clk_i);
      pins <= 4'hf;
      // Fault flags gated by supply state
      for (int i = 0; i < 8; i++) begin
         v = (i == 0) ? 8'hc1 : (8'($urandom) | 8'hc1);
         @(posedge ref_clk_i);
         below <= (i < 2) ? 5'h1f : 5'($urandom);
         power_fail_i <= 1'($urandom);
         low_battery_i <= 1'($urandom);
         i_host_model.wr(pmic_regs_pkg::ADDR_SUPPLY, v);
         repeat (3) @(posedge ref_clk_i);
         i_host_model.rd(pmic_regs_pkg::ADDR_FAULT, d);
         check(d, {power_fail_i, low_battery_i, below & v[5:1], 1'b0});
      end
      @(posedge ref_clk_i);
      below <= 5'h00;
      power_fail_i <= 1'b0;
      low_battery_i <= 1'b0;
      i_host_model.wr(pmic_regs_pkg::ADDR_SUPPLY, 8'hff);
      i_host_model.wr(pmic_regs_pkg::ADDR_MASK, 8'h00);
      int_after(3, 1'b1);
      @(posedge ref_clk_i);
      below <= 5'h01;
      int_after(3, 1'b0);
      i_host_model.wr(pmic_regs_pkg::ADDR_MASK, 8'h02);
      int_after(2, 1'b1);
      i_host_model.wr(pmic_regs_pkg::ADDR_MASK, 8'h00);
      int_after(2, 1'b0);
      i_host_model.rd(pmic_regs_pkg::ADDR_FAULT, d);
      check(d, 8'h02);
      int_after(2, 1'b1);
      @(posedge ref_clk_i);
      below <= 5'h00;
      int_after(3, 1'b1);
      @(posedge ref_clk_i);
      below <= 5'h01;
      int_after(3, 1'b0);
      @(posedge ref_clk_i);
      below <= 5'h00;
      // Lockout in mid-run restores all defaults
      i_host_model.wr(pmic_regs_pkg::ADDR_MASK, 8'h3e);
      i_host_model.wr(pmic_regs_pkg::ADDR_SUPPLY, 8'hc1);
      i_host_model.wr(pmic_regs_pkg::ADDR_CONV, 8'h00);
      @(posedge ref_clk_i);
      undervoltage_lockout_i <= 1'b1;
      @(posedge ref_clk_i);
      undervoltage_lockout_i <= 1'b0;
      i_host_model.rd(pmic_regs_pkg::ADDR_MASK, d);
      check(d, 8'hc0);
      i_host_model.rd(pmic_regs_pkg::ADDR_SUPPLY, d);
      check(d, 8'hff);
      i_host_model.rd(pmic_regs_pkg::ADDR_CONV, d);
      check(d, 8'hb1);
      check(on_now(), 8'h1f);
      close_out();
   end
endmodule
`default_nettype wire
